/* dv/asq_core_model.sv */
`timescale 1ns/10ps
module asq_core_model (
   input  wire       hclk,
   input  wire [2:0] mux_sel,
   input  wire       sample_en,
   input  wire [9:0] dac_code,
   input  wire [6:0] bias,
   output reg        comp_in
);
   reg [9:0] held_r;
   initial begin
      held_r = 10'h000;
      comp_in = 1'b0;
   end
   // level sits half a step above the code, so either compare convention yields it
   always @(posedge hclk) begin
      if (sample_en)
         held_r <= {mux_sel, 7'h00} + {3'h0, bias};
      comp_in <= {held_r, 1'b1} > {dac_code, 1'b0};
   end
endmodule // asq_core_model

/* dv/asq_top_properties.sv */
`timescale 1ns/10ps
module asq_top_chk (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire [2:0]  mux_sel,
   input wire        sample_en,
   input wire [9:0]  dac_code,
   input wire        irq
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire take = hsel && htrans[1] && hready;
   wire rd_gap = take && !hwrite && haddr[7:0] == 8'h1c;
   reg  wr_ph_r;
   // the flag can only drop after a register write has landed
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_ph_r <= 1'b0;
      else
         wr_ph_r <= take && hwrite;
   end
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   a_unmapped_zero: assert property (rd_gap |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_mux_hold: assert property (sample_en && $past(sample_en) |-> $stable(mux_sel))
      else $error("mux moved while sampling");
   a_sample_len: assert property ($rose(sample_en) |-> sample_en[*8])
      else $error("sampling window too short");
   a_first_trial: assert property ($fell(sample_en) |-> ##[0:60] dac_code == 10'h200)
      else $error("first trial code is not midscale");
   a_mux_conv: assert property ($fell(sample_en) |-> $stable(mux_sel)[*8])
      else $error("mux moved during conversion");
   a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !sample_en)
      else $error("outputs active after reset");
   a_irq_holds: assert property ($rose(irq) |-> irq[*3])
      else $error("interrupt dropped on its own");
   a_irq_drop: assert property ($fell(irq) |-> $past(wr_ph_r))
      else $error("interrupt fell without a write");
   c_irq: cover property ($rose(irq));
   c_clear: cover property ($fell(irq));
   c_sample: cover property ($rose(sample_en));
endmodule // asq_top_chk
bind asq_top asq_top_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .mux_sel(mux_sel), .sample_en(sample_en), .dac_code(dac_code), .irq(irq));

/* dv/asq_top_tb.sv */
`timescale 1ns/10ps
`include "asq_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module asq_top_tb;
   localparam [7:0] p_md = {`ASQ_OFS_MODE, 2'b00};
   localparam [7:0] p_ct = {`ASQ_OFS_CTRL, 2'b00};
   localparam [7:0] p_cs = {`ASQ_OFS_CHSEL, 2'b00};
   localparam [7:0] p_st = {`ASQ_OFS_STAT, 2'b00};
   localparam [7:0] p_bh = {`ASQ_OFS_BNDHI, 2'b00};
   localparam [7:0] p_bs = {`ASQ_OFS_BNDSTAT, 2'b00};
   reg         hclk = 1'b0;
   reg         hresetn = 1'b0;
   reg         hwrite = 1'b0;
   reg         timer_ovf = 1'b0;
   reg         start_pin = 1'b0;
   reg         se_q = 1'b0;
   reg  [1:0]  htrans = 2'h0;
   reg  [31:0] haddr = 32'h0;
   reg  [31:0] hwdata = 32'h0;
   reg  [6:0]  bias = 7'h11;
   reg  [2:0]  seq [0:63];
   wire [31:0] hrdata;
   wire        hreadyout, hresp, comp_in, sample_en, irq;
   wire [2:0]  mux_sel;
   wire [9:0]  dac_code;
   int         n_fail = 0, n_checks = 0, n_rise = 0, base = 0, ndone = 0, kw = 0;
   always #2 hclk = ~hclk;
   // log of channels in the order their sampling began
   always @(posedge hclk) begin
      se_q <= sample_en;
      if (sample_en && !se_q) begin
         seq[n_rise[5:0]] <= mux_sel;
         n_rise <= n_rise + 1;
      end
   end
   asq_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer_ovf(timer_ovf), .start_pin(start_pin),
      .comp_in(comp_in), .mux_sel(mux_sel), .sample_en(sample_en), .dac_code(dac_code),
      .irq(irq));
   asq_core_model i_core (.hclk(hclk), .mux_sel(mux_sel), .sample_en(sample_en),
      .dac_code(dac_code), .bias(bias), .comp_in(comp_in));
   task give_verdict;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task hs;
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 64) begin
         @(posedge hclk);
         k++;
      end
      if (k == 64) begin
         n_fail++;
         give_verdict;
      end
   endtask
   task wr(input [31:0] a, input [31:0] d);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= 1'b1;
      hs;
      htrans <= 2'b00;
      hwdata <= d;
      hs;
   endtask
   task rd(input [31:0] a, output [31:0] d);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= 1'b0;
      hs;
      htrans <= 2'b00;
      hs;
      d = hrdata;
   endtask
   task cr(input [31:0] a, input [31:0] e);
      logic [31:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask
   function [9:0] lv(input [2:0] c, input [6:0] b);
      lv = {c, 7'h00} + {3'h0, b};
   endfunction
   task cres(input [2:0] i, input [9:0] e);
      cr({24'h00_0000, `ASQ_OFS_RES0 + {3'h0, i}, 2'b00}, {22'h0, e});
   endtask
   // polling by bus would hide how many conversions had finished at the flag
   task wirq;
      kw = 0;
      @(posedge hclk);
      while (irq !== 1'b1 && kw < 20000) begin
         @(posedge hclk);
         kw++;
      end
      if (kw == 20000) begin
         n_fail++;
         give_verdict;
      end
      @(posedge hclk);
      ndone = n_rise - base - se_q;
   endtask
   task go(input [5:0] m, input [7:0] s, input [4:0] c);
      wr(p_md, m);
      wr(p_cs, s);
      base = n_rise;
      wr(p_ct, c);
   endtask
   task stp;
      logic [31:0] d;
      int k;
      wr(p_ct, 32'h0);
      d = 32'h4;
      k = 0;
      while (d[`ASQ_STAT_BUSY] !== 1'b0 && k < 2000) begin
         rd(p_st, d);
         k++;
      end
      `CHK(k < 2000, 1'b1)
      if (k == 2000)
         give_verdict;
      wr(p_st, 32'h3);
      wr(p_bs, 32'hff);
      $display("test ends at %0t after %0d conversions", $time, n_rise - base);
   endtask
   task scan_chk(input [7:0] s);
      int j;
      j = 0;
      for (int b = 0; b < 8; b++) begin
         if (s[b]) begin
            `CHK(seq[(base + j) % 64], b[2:0])
            cres(b[2:0], lv(b[2:0], bias));
            j++;
         end
      end
   endtask
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      cr(p_md, 32'h0);
      cr(p_bh, 32'h3ff);
      cr(32'h1c, 32'h0);
      wr(p_bh, 32'h100);
      go(6'h31, 8'h20, 5'h11);
      wirq;
      `CHK(kw < 1000, 1'b1)
      `CHK(ndone, 1)
      cres(3'h5, lv(3'h5, bias));
      cr(p_bs, 32'h20);
      wr(p_md, 32'h1);
      @(posedge hclk);
      `CHK(irq, 1'b1)
      wr(p_ct, 32'h0);
      @(posedge hclk);
      `CHK(irq, 1'b0)
      cr(p_st, 32'h3);
      stp;
      wr(p_bh, 32'h3ff);
      go(6'h01, 8'ha5, 5'h11);
      wirq;
      `CHK(ndone, 4)
      scan_chk(8'ha5);
      stp;
      `CHK(n_rise - base, 4)
      go(6'h09, 8'hf6, 5'h11);
      wirq;
      `CHK(ndone, 4)
      wr(p_st, 32'h1);
      wirq;
      `CHK(ndone, 6)
      scan_chk(8'hf6);
      stp;
      go(6'h0a, 8'h08, 5'h11);
      wirq;
      `CHK(ndone, 4)
      wr(p_st, 32'h1);
      wirq;
      `CHK(ndone, 8)
      bias <= 7'h55;
      for (int i = 0; i < 8; i++)
         cres(i[2:0], lv(3'h3, 7'h11));
      wr(p_st, 32'h1);
      wirq;
      wr(p_st, 32'h1);
      wirq;
      `CHK(ndone, 16)
      for (int i = 0; i < 8; i++)
         cres(i[2:0], lv(3'h3, 7'h55));
      stp;
      go(6'h02, 8'h48, 5'h11);
      wirq;
      `CHK(ndone, 8)
      for (int i = 0; i < 8; i++)
         cres(i[2:0], lv(i[0] ? 3'h6 : 3'h3, bias));
      stp;
      go(6'h04, 8'h81, 5'h11);
      wirq;
      `CHK(ndone, 2)
      bias <= 7'h2a;
      wr(p_st, 32'h1);
      wirq;
      `CHK(ndone, 4)
      `CHK(seq[(base + 2) % 64], 3'h0)
      cres(3'h0, lv(3'h0, 7'h2a));
      cres(3'h7, lv(3'h7, 7'h2a));
      stp;
      go(6'h00, 8'h06, 5'h12);
      start_pin <= 1'b1;
      wirq;
      `CHK(ndone, 1)
      start_pin <= 1'b0;
      wr(p_st, 32'h1);
      start_pin <= 1'b1;
      wirq;
      `CHK(ndone, 2)
      scan_chk(8'h06);
      stp;
      go(6'h00, 8'h10, 5'h15);
      timer_ovf <= 1'b1;
      @(posedge hclk);
      timer_ovf <= 1'b0;
      wirq;
      `CHK(ndone, 1)
      cres(3'h4, lv(3'h4, bias));
      stp;
      // pin rests high here, so the falling edge is the only start
      go(6'h00, 8'h01, 5'h1a);
      start_pin <= 1'b0;
      wirq;
      `CHK(ndone, 1)
      cres(3'h0, lv(3'h0, bias));
      stp;
      // an undefined mode code must not start anything
      go(6'h03, 8'h01, 5'h11);
      repeat (60) @(posedge hclk);
      `CHK(n_rise - base, 0)
      `CHK(irq, 1'b0)
      stp;
      give_verdict;
   end
endmodule // asq_top_tb

/* verilog/asq_map.vh */
`ifndef ASQ_MAP_VH
`define ASQ_MAP_VH
// register word indices; the byte address is four times the index
`define ASQ_OFS_MODE      6'h00
`define ASQ_OFS_CTRL      6'h01
`define ASQ_OFS_CHSEL     6'h02
`define ASQ_OFS_STAT      6'h03
`define ASQ_OFS_BNDHI     6'h04
`define ASQ_OFS_BNDLO     6'h05
`define ASQ_OFS_BNDSTAT   6'h06
`define ASQ_OFS_RES0      6'h08
// mode_control_reg fields
`define ASQ_MODE_SINGLE   0
`define ASQ_MODE_CONT     1
`define ASQ_MODE_LOOP     2
`define ASQ_MODE_INT4     3
`define ASQ_MODE_BNDOUT   4
`define ASQ_MODE_BNDEN    5
`define ASQ_MODE_W        6
`define ASQ_MODE_RST      6'h00
// control fields
`define ASQ_CTRL_SM_LO    0
`define ASQ_CTRL_SM_HI    1
`define ASQ_CTRL_TMR      2
`define ASQ_CTRL_EDGE     3
`define ASQ_CTRL_IRQEN    4
`define ASQ_CTRL_W        5
`define ASQ_CTRL_RST      5'h00
// status fields
`define ASQ_STAT_DONE     0
`define ASQ_STAT_BND      1
`define ASQ_STAT_BUSY     2
`define ASQ_CHSEL_RST     8'h00
`define ASQ_BNDHI_RST     10'h3ff
`define ASQ_BNDLO_RST     10'h000
// timing
`define ASQ_CLK_MHZ       250
`define ASQ_ADCLK_KHZ     9000
`define ASQ_CONV_NS       4000
`define ASQ_ADC_DIV       ((`ASQ_CLK_MHZ * 1000 + `ASQ_ADCLK_KHZ - 1) / `ASQ_ADCLK_KHZ)
`define ASQ_SAMP_TICKS    4'h8
`define ASQ_RES_W         10
`endif

/* verilog/asq_sar.v */
`timescale 1ns/10ps
`include "asq_map.vh"
module asq_sar (
   input  wire                     hclk,
   input  wire                     hresetn,
   input  wire                     tick,
   input  wire                     start,
   input  wire                     comp_in,
   output reg                      sample_en,
   output reg  [`ASQ_RES_W-1:0]    dac_code,
   output wire                     busy,
   output reg                      done,
   output reg  [`ASQ_RES_W-1:0]    result
);
   localparam S_IDLE = 2'd0;
   localparam S_SAMP = 2'd1;
   localparam S_SET  = 2'd2;
   localparam S_CHK  = 2'd3;

   reg [1:0]             st_r;
   reg [3:0]             cnt_r;
   reg [`ASQ_RES_W-1:0]  sar_r;
   reg [`ASQ_RES_W-1:0]  bit_r;
   reg                   comp_m_r;
   reg                   comp_s_r;

   assign busy = (st_r != S_IDLE);

   // comparator is asynchronous to hclk
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comp_m_r <= 1'b0;
         comp_s_r <= 1'b0;
      end else begin
         comp_m_r <= comp_in;
         comp_s_r <= comp_m_r;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r      <= S_IDLE;
         cnt_r     <= 4'h0;
         sar_r     <= {`ASQ_RES_W{1'b0}};
         bit_r     <= {`ASQ_RES_W{1'b0}};
         sample_en <= 1'b0;
         dac_code  <= {`ASQ_RES_W{1'b0}};
         done      <= 1'b0;
         result    <= {`ASQ_RES_W{1'b0}};
      end else begin
         done <= 1'b0;
         case (st_r)
            S_IDLE: begin
               if (start) begin
                  st_r      <= S_SAMP;
                  cnt_r     <= 4'h0;
                  sample_en <= 1'b1;
               end
            end
            S_SAMP: begin
               if (tick) begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `ASQ_SAMP_TICKS - 4'h1) begin
                     sample_en <= 1'b0;
                     sar_r     <= {`ASQ_RES_W{1'b0}};
                     bit_r     <= {1'b1, {(`ASQ_RES_W-1){1'b0}}};
                     st_r      <= S_SET;
                  end
               end
            end
            S_SET: begin
               if (tick) begin
                  dac_code <= sar_r | bit_r;
                  st_r     <= S_CHK;
               end
            end
            S_CHK: begin
               // one tick lets the dac and comparator settle before sampling
               if (tick) begin
                  if (comp_s_r)
                     sar_r <= sar_r | bit_r;
                  if (bit_r[0]) begin
                     // result only moves once every bit is decided
                     result <= comp_s_r ? (sar_r | bit_r) : sar_r;
                     done   <= 1'b1;
                     st_r   <= S_IDLE;
                  end else begin
                     bit_r <= bit_r >> 1;
                     st_r  <= S_SET;
                  end
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule // asq_sar

/* verilog/asq_top.v */
// How it works
// - eight-input mux feeds 10-bit sar conversion
// - fixed single: one conversion into channel pair
// - fixed continuous: pairs zero to seven, wrap
// - fixed continuous: interrupt every four or eight
// - scan single: each selected channel once
// - scan visits channels lsb to msb
// - scan interrupts at end, optionally after four
// - one selected bit equals fixed single
// - scan continuous restarts at first channel
// - repeated passes overwrite stored results
// - dual: first even pairs, second odd pairs
// - dual: interrupt every four or eight
// - start by timer, software, or pin edge
// - conversion within 4 us at 9 MHz
// - completion by interrupt or polled flag
// - single step: one channel per start
// - boundary compare, interrupt, per-channel status
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "asq_map.vh"
module asq_top (
   input  wire                  hclk,
   input  wire                  hresetn,
   input  wire                  hsel,
   input  wire [31:0]           haddr,
   input  wire [1:0]            htrans,
   input  wire                  hwrite,
   input  wire [2:0]            hsize,
   input  wire [31:0]           hwdata,
   input  wire                  hready,
   output reg  [31:0]           hrdata,
   output wire                  hreadyout,
   output wire                  hresp,
   input  wire                  timer_ovf,
   input  wire                  start_pin,
   input  wire                  comp_in,
   output wire [2:0]            mux_sel,
   output wire                  sample_en,
   output wire [9:0]            dac_code,
   output wire                  irq
);
   localparam integer ADC_DIV_I = `ASQ_ADC_DIV;
   localparam [4:0]   ADC_DIV   = ADC_DIV_I[4:0];

   // lowest selected channel at or above from; msb is the found bit
   function [3:0] next_ch;
      input [7:0] sel;
      input [3:0] from;
      integer i;
      begin
         next_ch = 4'h0;
         for (i = 7; i >= 0; i = i - 1) begin
            if (sel[i] && (i >= from))
               next_ch = {1'b1, i[2:0]};
         end
      end
   endfunction

   reg  [`ASQ_MODE_W-1:0]  mode_r;
   reg  [`ASQ_CTRL_W-1:0]  ctrl_r;
   reg  [7:0]              chsel_r;
   reg  [9:0]              bnd_hi_r;
   reg  [9:0]              bnd_lo_r;
   reg  [7:0]              bnd_stat_r;
   reg                     done_flag_r;
   reg                     bnd_flag_r;
   reg  [9:0]              res_r [0:7];
   reg                     dph_r;
   reg                     dwr_r;
   reg  [5:0]              dadr_r;
   reg  [4:0]              div_r;
   reg                     tick_r;
   reg                     pin_m_r;
   reg                     pin_s_r;
   reg                     pin_d_r;
   reg                     imm_r;
   reg                     run_r;
   reg                     go_r;
   reg  [2:0]              cur_r;
   reg  [2:0]              pair_r;
   reg  [2:0]              cnt_r;
   reg  [2:0]              pass_r;
   reg                     ph_r;
   reg  [3:0]              pop;
   integer                 k;

   wire        sar_busy;
   wire        sar_done;
   wire [9:0]  sar_res;
   wire        wr_en   = dph_r & dwr_r;
   wire        ap_ok   = hsel & htrans[1] & hready;
   wire [2:0]  mbits   = mode_r[`ASQ_MODE_LOOP:`ASQ_MODE_SINGLE];
   wire [1:0]  smode   = ctrl_r[`ASQ_CTRL_SM_HI:`ASQ_CTRL_SM_LO];
   wire        tmr_on  = ctrl_r[`ASQ_CTRL_TMR];
   wire        int4    = mode_r[`ASQ_MODE_INT4];
   wire        bnd_en  = mode_r[`ASQ_MODE_BNDEN];
   wire        irq_en  = ctrl_r[`ASQ_CTRL_IRQEN];
   wire        m_step  = (mbits == 3'b000);
   wire        m_sing  = (mbits == 3'b001);
   wire        m_cont  = (mbits == 3'b010);
   wire        m_loop  = (mbits == 3'b100);
   wire        m_ok    = m_step | m_sing | m_cont | m_loop;
   wire        dual    = m_cont & (pop == 4'd2);
   wire [3:0]  first   = next_ch(chsel_r, 4'h0);
   wire [3:0]  second  = next_ch(chsel_r, {1'b0, first[2:0]} + 4'h1);
   wire [3:0]  nxt     = next_ch(chsel_r, {1'b0, cur_r} + 4'h1);
   wire        last    = ~nxt[3];
   wire [3:0]  sel_first = next_ch(hwdata[7:0], 4'h0);
   wire        go_on   = (smode != 2'b00) | tmr_on;
   wire        pin_edg = ctrl_r[`ASQ_CTRL_EDGE] ? (pin_d_r & ~pin_s_r) : (pin_s_r & ~pin_d_r);
   wire        trig    = tmr_on ? (smode != 2'b00) & timer_ovf
                       : (smode == 2'b10) ? pin_edg : imm_r;
   // triggers while a run is in progress are dropped
   wire        start_evt = trig & m_ok & first[3] & ~run_r;
   wire [2:0]  dst     = m_cont ? pair_r : cur_r;
   wire        in_rng  = (sar_res >= bnd_lo_r) & (sar_res <= bnd_hi_r);
   wire        bnd_hit = bnd_en & (mode_r[`ASQ_MODE_BNDOUT] ? ~in_rng : in_rng);
   wire        c_irq   = m_cont ? (int4 ? (cnt_r[1:0] == 2'b11) : (cnt_r == 3'b111))
                       : m_step ? 1'b1
                       : (last | (int4 & (pass_r == 3'd3)));

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign mux_sel   = cur_r;
   assign irq       = (done_flag_r & irq_en) | (bnd_flag_r & bnd_en);

   always @* begin
      pop = 4'h0;
      for (k = 0; k < 8; k = k + 1)
         pop = pop + {3'b000, chsel_r[k]};
   end

   // ahb-lite slave: zero wait states, registered read data
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_r  <= 1'b0;
         dwr_r  <= 1'b0;
         dadr_r <= 6'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         dph_r  <= ap_ok;
         dwr_r  <= hwrite;
         dadr_r <= haddr[7:2];
         if (ap_ok & ~hwrite) begin
            if (haddr[7:5] == 3'b001)
               hrdata <= {22'h00_0000, res_r[haddr[4:2]]};
            else begin
               case (haddr[7:2])
                  `ASQ_OFS_MODE:    hrdata <= {26'h000_0000, mode_r};
                  `ASQ_OFS_CTRL:    hrdata <= {27'h000_0000, ctrl_r};
                  `ASQ_OFS_CHSEL:   hrdata <= {24'h00_0000, chsel_r};
                  `ASQ_OFS_STAT:    hrdata <= {29'h000_0000, run_r | sar_busy,
                                               bnd_flag_r, done_flag_r};
                  `ASQ_OFS_BNDHI:   hrdata <= {22'h00_0000, bnd_hi_r};
                  `ASQ_OFS_BNDLO:   hrdata <= {22'h00_0000, bnd_lo_r};
                  `ASQ_OFS_BNDSTAT: hrdata <= {24'h00_0000, bnd_stat_r};
                  default:          hrdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // a-to-d clock enable kept at or below the converter's 9 MHz limit
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r  <= 5'h00;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_r == ADC_DIV - 5'h01);
         div_r  <= (div_r == ADC_DIV - 5'h01) ? 5'h00 : div_r + 5'h01;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_m_r <= 1'b0;
         pin_s_r <= 1'b0;
         pin_d_r <= 1'b0;
      end else begin
         pin_m_r <= start_pin;
         pin_s_r <= pin_m_r;
         pin_d_r <= pin_s_r;
      end
   end

   // register writes and hardware-set flags; a set beats a same-cycle clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r      <= `ASQ_MODE_RST;
         ctrl_r      <= `ASQ_CTRL_RST;
         chsel_r     <= `ASQ_CHSEL_RST;
         bnd_hi_r    <= `ASQ_BNDHI_RST;
         bnd_lo_r    <= `ASQ_BNDLO_RST;
         bnd_stat_r  <= 8'h00;
         done_flag_r <= 1'b0;
         bnd_flag_r  <= 1'b0;
         imm_r       <= 1'b0;
      end else begin
         imm_r <= 1'b0;
         if (wr_en) begin
            case (dadr_r)
               `ASQ_OFS_MODE:  mode_r <= hwdata[`ASQ_MODE_W-1:0];
               `ASQ_OFS_CTRL: begin
                  ctrl_r <= hwdata[`ASQ_CTRL_W-1:0];
                  imm_r  <= (hwdata[1:0] == 2'b01) & ~hwdata[`ASQ_CTRL_TMR];
               end
               `ASQ_OFS_CHSEL: chsel_r  <= hwdata[7:0];
               `ASQ_OFS_BNDHI: bnd_hi_r <= hwdata[9:0];
               `ASQ_OFS_BNDLO: bnd_lo_r <= hwdata[9:0];
               `ASQ_OFS_STAT: begin
                  if (hwdata[`ASQ_STAT_DONE])
                     done_flag_r <= 1'b0;
                  if (hwdata[`ASQ_STAT_BND])
                     bnd_flag_r <= 1'b0;
               end
               `ASQ_OFS_BNDSTAT: bnd_stat_r <= bnd_stat_r & ~hwdata[7:0];
               default: ;
            endcase
         end
         if (sar_done & run_r) begin
            if (c_irq)
               done_flag_r <= 1'b1;
            if (bnd_hit) begin
               bnd_flag_r      <= 1'b1;
               bnd_stat_r[cur_r] <= 1'b1;
            end
         end
      end
   end

   // result pairs: written only by a finished conversion
   always @(posedge hclk) begin
      if (sar_done & run_r)
         res_r[dst] <= sar_res;
   end

   // scan sequencer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_r  <= 1'b0;
         go_r   <= 1'b0;
         cur_r  <= 3'h0;
         pair_r <= 3'h0;
         cnt_r  <= 3'h0;
         pass_r <= 3'h0;
         ph_r   <= 1'b0;
      end else begin
         go_r <= 1'b0;
         if (start_evt) begin
            run_r <= 1'b1;
            go_r  <= 1'b1;
         end else if (sar_done & run_r) begin
            pair_r <= pair_r + 3'h1;
            cnt_r  <= cnt_r + 3'h1;
            pass_r <= last ? 3'h0 : pass_r + 3'h1;
            if (m_cont) begin
               ph_r  <= dual & ~ph_r;
               cur_r <= (dual & ~ph_r) ? second[2:0] : first[2:0];
               run_r <= go_on;
               go_r  <= go_on;
            end else if (m_step) begin
               cur_r <= last ? first[2:0] : nxt[2:0];
               run_r <= 1'b0;
            end else begin
               cur_r <= last ? first[2:0] : nxt[2:0];
               run_r <= go_on & (m_loop | ~last);
               go_r  <= go_on & (m_loop | ~last);
            end
         end
         // a select rewrite overrides the pointers but never swallows a completion
         if (wr_en & (dadr_r == `ASQ_OFS_CHSEL)) begin
            // rewriting the select resets the mux to the first channel
            cur_r  <= sel_first[2:0];
            pair_r <= 3'h0;
            cnt_r  <= 3'h0;
            pass_r <= 3'h0;
            ph_r   <= 1'b0;
         end
      end
   end

   asq_sar u_sar (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .tick      (tick_r),
      .start     (go_r),
      .comp_in   (comp_in),
      .sample_en (sample_en),
      .dac_code  (dac_code),
      .busy      (sar_busy),
      .done      (sar_done),
      .result    (sar_res)
   );
endmodule // asq_top
